// ---- common/stcu_pkg.sv ----
// Shared constants and types of the synchronised timer capture group
package stcu_pkg;
  localparam int          STCU_CH        = 4;
  localparam int          STCU_AW        = 8;
  localparam int          STCU_DW        = 32;
  // Register index inside one channel block; byte address is index times four
  localparam logic [3:0]  STCU_REG_RUN   = 4'h0;
  localparam logic [3:0]  STCU_REG_CTRL  = 4'h1;
  localparam logic [3:0]  STCU_REG_MODE  = 4'h2;
  localparam logic [3:0]  STCU_REG_TCTL  = 4'h3;
  localparam logic [3:0]  STCU_REG_CMP0  = 4'h4;
  localparam logic [3:0]  STCU_REG_CMP1  = 4'h5;
  localparam logic [3:0]  STCU_REG_CAP0  = 4'h6;
  localparam logic [3:0]  STCU_REG_CAP1  = 4'h7;
  localparam logic [3:0]  STCU_REG_COUNT = 4'h8;
  localparam logic [3:0]  STCU_REG_STAT  = 4'h9;
  // Address slices: channel select and register index
  localparam int          STCU_CH_HI     = 7;
  localparam int          STCU_CH_LO     = 6;
  localparam int          STCU_IDX_HI    = 5;
  localparam int          STCU_IDX_LO    = 2;
  // Field positions
  localparam int          STCU_RUN_CNT   = 0;
  localparam int          STCU_RUN_PRE   = 2;
  localparam int          STCU_CTRL_SYNC = 0;
  localparam int          STCU_MODE_EXT  = 0;
  localparam int          STCU_MODE_EDGE = 1;
  localparam int          STCU_TCTL_M0   = 0;
  localparam int          STCU_TCTL_M1   = 1;
  localparam int          STCU_TCTL_CAP0 = 2;
  localparam int          STCU_STAT_FLOP = 0;
  localparam int          STCU_STAT_RUN  = 1;
  // Reset values
  localparam logic [15:0] STCU_RST16     = 16'h0000;
  localparam logic [2:0]  STCU_RST3      = 3'h0;
  localparam logic [31:0] STCU_ZERO32    = 32'h0000_0000;
  // Prescaler: one count tick every eight clocks
  localparam logic [2:0]  STCU_PRE_LAST  = 3'h7;
  localparam logic [2:0]  STCU_PRE_STEP  = 3'h1;
  localparam logic [15:0] STCU_CNT_STEP  = 16'h0001;
  // Bus answers
  localparam logic [1:0]  STCU_OKAY      = 2'h0;
  localparam logic [1:0]  STCU_SLVERR    = 2'h2;
  typedef enum logic [1:0] {
    STCU_EDGE_OFF  = 2'h0,
    STCU_EDGE_PINS = 2'h1,
    STCU_EDGE_IN0  = 2'h2,
    STCU_EDGE_PEER = 2'h3
  } stcu_edge_t;
endpackage

// ---- design/stcu_channel.sv ----
// One timer channel: counter, prescaler, capture, compare and toggle flop
`timescale 1ns/1ps
module stcu_channel
  import stcu_pkg::*;
(
  input  wire logic        mclk_in,
  input  wire logic        resetn_in,
  input  wire logic        run_in,
  input  wire logic        pre_run_in,
  input  wire logic        ext_clk_in,
  input  wire logic [1:0]  edge_sel_in,
  input  wire logic [2:0]  tctl_in,
  input  wire logic [15:0] cmp0_in,
  input  wire logic [15:0] cmp1_in,
  input  wire logic        cap_pin0_in,
  input  wire logic        cap_pin1_in,
  input  wire logic        peer_toggle_in,
  output logic      [15:0] count_out,
  output logic      [15:0] capture0_out,
  output logic      [15:0] capture1_out,
  output logic             toggle_out,
  output logic             cap0_irq_out,
  output logic             cap1_irq_out,
  output logic             match_irq_out
);
  typedef struct packed {
    logic [2:0]  in0;
    logic [2:0]  in1;
    logic        peer;
    logic [2:0]  pre;
    logic [15:0] count;
    logic [15:0] cap0;
    logic [15:0] cap1;
    logic        flop;
    logic        irq0;
    logic        irq1;
    logic        irqm;
  } stcu_ch_st_t;

  stcu_ch_st_t r;
  stcu_ch_st_t next_r;
  logic        rise0;
  logic        fall0;
  logic        rise1;
  logic        tick;
  logic        ev0;
  logic        ev1;
  logic        m0;
  logic        m1;
  logic [15:0] cnt_inc;

  always_comb begin
    next_r = r;
    next_r.in0 = {r.in0[1:0], cap_pin0_in};
    next_r.in1 = {r.in1[1:0], cap_pin1_in};
    next_r.peer = peer_toggle_in;
    rise0 = r.in0[1] & ~r.in0[2];
    fall0 = ~r.in0[1] & r.in0[2];
    rise1 = r.in1[1] & ~r.in1[2];
    cnt_inc = r.count + STCU_CNT_STEP;
    if (ext_clk_in) begin
      tick = run_in & rise0;
    end else begin
      tick = run_in & pre_run_in & (r.pre == STCU_PRE_LAST);
    end
    if (run_in && pre_run_in && !ext_clk_in) begin
      next_r.pre = (r.pre == STCU_PRE_LAST) ? STCU_RST3 : r.pre + STCU_PRE_STEP;
    end else begin
      next_r.pre = STCU_RST3;
    end
    if (!run_in) begin
      next_r.count = STCU_RST16;
    end else if (tick) begin
      next_r.count = cnt_inc;
    end
    m0 = tick && (cnt_inc == cmp0_in);
    m1 = tick && (cnt_inc == cmp1_in);
    unique case (stcu_edge_t'(edge_sel_in))
      STCU_EDGE_OFF: begin
        ev0 = 1'b0;
        ev1 = 1'b0;
      end
      STCU_EDGE_PINS: begin
        ev0 = rise0;
        ev1 = rise1;
      end
      STCU_EDGE_IN0: begin
        ev0 = rise0;
        ev1 = fall0;
      end
      STCU_EDGE_PEER: begin
        ev0 = peer_toggle_in & ~r.peer;
        ev1 = ~peer_toggle_in & r.peer;
      end
    endcase
    if (ev0) begin
      next_r.cap0 = r.count;
    end
    if (ev1) begin
      next_r.cap1 = r.count;
    end
    next_r.flop = r.flop
                ^ (m0 & tctl_in[STCU_TCTL_M0])
                ^ (m1 & tctl_in[STCU_TCTL_M1])
                ^ (ev0 & tctl_in[STCU_TCTL_CAP0]);
    next_r.irq0 = ev0;
    next_r.irq1 = ev1;
    next_r.irqm = m1;
  end

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign count_out     = r.count;
  assign capture0_out  = r.cap0;
  assign capture1_out  = r.cap1;
  assign toggle_out    = r.flop;
  assign cap0_irq_out  = r.irq0;
  assign cap1_irq_out  = r.irq1;
  assign match_irq_out = r.irqm;
endmodule // stcu_channel

// ---- design/stcu_timer_group.sv ----
// Four-channel timer group with synchronous start and an AXI4-Lite register slave
// Function
// - Channels grouped by four, lowest is master
// - Slaves begin counting on master's edge
// - Per-channel sync select: 0 alone, 1 master
// - Synced slave starts without own run bits
// - 16-bit up-counter on prescaler clock
// - Input 0 rise captures into register 0
// - Both match enables toggle flop on matches
// - Capture 0 may invert the toggle flop
// - Input 0 rises may clock the counter
// - Mode 11 captures on peer toggle edges
// - Input 0 rise and fall capture both
// - Falling capture raises capture 1 request
// - Input 1 rise captures into register 1
// - Input 0 rise raises capture 0 request
//
// Implementation choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
module stcu_timer_group
  import stcu_pkg::*;
(
  input  wire logic                mclk_in,
  input  wire logic                resetn_in,
  input  wire logic [STCU_AW-1:0]  s_axi_awaddr_in,
  input  wire logic                s_axi_awvalid_in,
  output logic                     s_axi_awready_out,
  input  wire logic [STCU_DW-1:0]  s_axi_wdata_in,
  input  wire logic [3:0]          s_axi_wstrb_in,
  input  wire logic                s_axi_wvalid_in,
  output logic                     s_axi_wready_out,
  output logic [1:0]               s_axi_bresp_out,
  output logic                     s_axi_bvalid_out,
  input  wire logic                s_axi_bready_in,
  input  wire logic [STCU_AW-1:0]  s_axi_araddr_in,
  input  wire logic                s_axi_arvalid_in,
  output logic                     s_axi_arready_out,
  output logic [STCU_DW-1:0]       s_axi_rdata_out,
  output logic [1:0]               s_axi_rresp_out,
  output logic                     s_axi_rvalid_out,
  input  wire logic                s_axi_rready_in,
  input  wire logic [STCU_CH-1:0]  capture_input_0_in,
  input  wire logic [STCU_CH-1:0]  capture_input_1_in,
  output logic      [STCU_CH-1:0]  toggle_output_pin_out,
  output logic      [STCU_CH-1:0]  capture0_irq_out,
  output logic      [STCU_CH-1:0]  capture1_irq_out,
  output logic      [STCU_CH-1:0]  match_irq_out
);
  typedef struct packed {
    logic                       aw_held;
    logic [STCU_AW-1:0]         aw_addr;
    logic                       w_held;
    logic [STCU_DW-1:0]         w_data;
    logic [3:0]                 w_strb;
    logic                       bvalid;
    logic [1:0]                 bresp;
    logic                       rvalid;
    logic [STCU_DW-1:0]         rdata;
    logic [1:0]                 rresp;
    logic [STCU_CH-1:0]         cnt_run;
    logic [STCU_CH-1:0]         pre_run;
    logic [STCU_CH-1:0]         sync;
    logic [STCU_CH-1:0][2:0]    mode;
    logic [STCU_CH-1:0][2:0]    tctl;
    logic [STCU_CH-1:0][15:0]   cmp0;
    logic [STCU_CH-1:0][15:0]   cmp1;
  } stcu_top_st_t;

  stcu_top_st_t              r;
  stcu_top_st_t              next_r;
  logic [STCU_CH-1:0]        run_eff;
  logic [STCU_CH-1:0]        pre_eff;
  logic [STCU_CH-1:0][15:0]  count;
  logic [STCU_CH-1:0][15:0]  cap0;
  logic [STCU_CH-1:0][15:0]  cap1;
  logic [STCU_CH-1:0]        flop;
  logic [STCU_CH-1:0]        peer;
  logic                      aw_take;
  logic                      w_take;
  logic                      ar_take;
  logic                      wr_go;
  logic [32:0]               wr_old;
  logic [32:0]               rd_val;
  logic [STCU_DW-1:0]        wr_val;
  logic [1:0]                wr_ch;
  logic [3:0]                wr_idx;

  // Readback of one register: bit 32 flags a mapped address
  function automatic logic [32:0] reg_read(input logic [STCU_AW-1:0] a);
    logic [1:0]  ch;
    logic [3:0]  idx;
    logic [32:0] v;
    ch  = a[STCU_CH_HI:STCU_CH_LO];
    idx = a[STCU_IDX_HI:STCU_IDX_LO];
    v   = {1'b1, STCU_ZERO32};
    case (idx)
      STCU_REG_RUN: begin
        v[STCU_RUN_CNT] = r.cnt_run[ch];
        v[STCU_RUN_PRE] = r.pre_run[ch];
      end
      STCU_REG_CTRL: begin
        v[STCU_CTRL_SYNC] = r.sync[ch];
      end
      STCU_REG_MODE: begin
        v[2:0] = r.mode[ch];
      end
      STCU_REG_TCTL: begin
        v[2:0] = r.tctl[ch];
      end
      STCU_REG_CMP0: begin
        v[15:0] = r.cmp0[ch];
      end
      STCU_REG_CMP1: begin
        v[15:0] = r.cmp1[ch];
      end
      STCU_REG_CAP0: begin
        v[15:0] = cap0[ch];
      end
      STCU_REG_CAP1: begin
        v[15:0] = cap1[ch];
      end
      STCU_REG_COUNT: begin
        v[15:0] = count[ch];
      end
      STCU_REG_STAT: begin
        v[STCU_STAT_FLOP] = flop[ch];
        v[STCU_STAT_RUN]  = run_eff[ch];
      end
      default: begin
        v = {1'b0, STCU_ZERO32};
      end
    endcase
    return v;
  endfunction

  // Byte-lane merge of write data over the current contents
  function automatic logic [STCU_DW-1:0] merge(input logic [STCU_DW-1:0] old,
                                               input logic [STCU_DW-1:0] nw,
                                               input logic [3:0]         strb);
    logic [STCU_DW-1:0] m;
    m = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        m[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return m;
  endfunction

  assign s_axi_awready_out = !r.aw_held && !r.bvalid;
  assign s_axi_wready_out  = !r.w_held && !r.bvalid;
  assign s_axi_arready_out = !r.rvalid;
  assign s_axi_bvalid_out  = r.bvalid;
  assign s_axi_bresp_out   = r.bresp;
  assign s_axi_rvalid_out  = r.rvalid;
  assign s_axi_rdata_out   = r.rdata;
  assign s_axi_rresp_out   = r.rresp;

  assign aw_take = s_axi_awvalid_in && s_axi_awready_out;
  assign w_take  = s_axi_wvalid_in && s_axi_wready_out;
  assign ar_take = s_axi_arvalid_in && s_axi_arready_out;
  assign wr_go   = r.aw_held && r.w_held && !r.bvalid;
  assign wr_ch   = r.aw_addr[STCU_CH_HI:STCU_CH_LO];
  assign wr_idx  = r.aw_addr[STCU_IDX_HI:STCU_IDX_LO];
  // A process wakes on what the functions read, an assign only on their arguments
  always_comb begin
    wr_old = reg_read(r.aw_addr);
    rd_val = reg_read(s_axi_araddr_in);
    wr_val = merge(wr_old[31:0], r.w_data, r.w_strb);
  end

  always_comb begin
    next_r = r;
    if (s_axi_bready_in && r.bvalid) begin
      next_r.bvalid = 1'b0;
    end
    if (s_axi_rready_in && r.rvalid) begin
      next_r.rvalid = 1'b0;
    end
    if (aw_take) begin
      next_r.aw_held = 1'b1;
      next_r.aw_addr = s_axi_awaddr_in;
    end
    if (w_take) begin
      next_r.w_held = 1'b1;
      next_r.w_data = s_axi_wdata_in;
      next_r.w_strb = s_axi_wstrb_in;
    end
    if (wr_go) begin
      next_r.aw_held = 1'b0;
      next_r.w_held  = 1'b0;
      next_r.bvalid  = 1'b1;
      next_r.bresp   = wr_old[32] ? STCU_OKAY : STCU_SLVERR;
      case (wr_idx)
        STCU_REG_RUN: begin
          next_r.cnt_run[wr_ch] = wr_val[STCU_RUN_CNT];
          next_r.pre_run[wr_ch] = wr_val[STCU_RUN_PRE];
        end
        STCU_REG_CTRL: begin
          next_r.sync[wr_ch] = wr_val[STCU_CTRL_SYNC];
        end
        STCU_REG_MODE: begin
          next_r.mode[wr_ch] = wr_val[2:0];
        end
        STCU_REG_TCTL: begin
          next_r.tctl[wr_ch] = wr_val[2:0];
        end
        STCU_REG_CMP0: begin
          next_r.cmp0[wr_ch] = wr_val[15:0];
        end
        STCU_REG_CMP1: begin
          next_r.cmp1[wr_ch] = wr_val[15:0];
        end
        default: begin
          next_r.bresp = wr_old[32] ? STCU_OKAY : STCU_SLVERR;
        end
      endcase
    end
    if (ar_take) begin
      next_r.rvalid = 1'b1;
      next_r.rdata  = rd_val[31:0];
      next_r.rresp  = rd_val[32] ? STCU_OKAY : STCU_SLVERR;
    end
  end

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // Channel 0 is the group master; its own sync select has no effect
  genvar i;
  generate
    for (i = 0; i < STCU_CH; i++) begin : g_ch
      if (i == 0) begin : g_master
        assign run_eff[i] = r.cnt_run[i];
        assign pre_eff[i] = r.pre_run[i];
      end else begin : g_slave
        // A synced slave follows the master's run bits on the same edge
        assign run_eff[i] = r.sync[i] ? run_eff[0] : r.cnt_run[i];
        assign pre_eff[i] = r.sync[i] ? pre_eff[0] : r.pre_run[i];
      end
      // Peer toggle source is the previous channel of the group
      assign peer[i] = flop[(i + STCU_CH - 1) % STCU_CH];
      stcu_channel u_ch (
        .mclk_in        (mclk_in),
        .resetn_in      (resetn_in),
        .run_in         (run_eff[i]),
        .pre_run_in     (pre_eff[i]),
        .ext_clk_in     (r.mode[i][STCU_MODE_EXT]),
        .edge_sel_in    (r.mode[i][STCU_MODE_EDGE +: 2]),
        .tctl_in        (r.tctl[i]),
        .cmp0_in        (r.cmp0[i]),
        .cmp1_in        (r.cmp1[i]),
        .cap_pin0_in    (capture_input_0_in[i]),
        .cap_pin1_in    (capture_input_1_in[i]),
        .peer_toggle_in (peer[i]),
        .count_out      (count[i]),
        .capture0_out   (cap0[i]),
        .capture1_out   (cap1[i]),
        .toggle_out     (flop[i]),
        .cap0_irq_out   (capture0_irq_out[i]),
        .cap1_irq_out   (capture1_irq_out[i]),
        .match_irq_out  (match_irq_out[i])
      );
    end
  endgenerate

  assign toggle_output_pin_out = flop;
endmodule // stcu_timer_group

// ---- dv/stcu_timer_group_props.sv ----
// Port-level assertions for the timer group
`timescale 1ns/1ps
module stcu_timer_group_props
  import stcu_pkg::*;
(
  input logic               mclk_in,
  input logic               resetn_in,
  input logic [STCU_AW-1:0] s_axi_awaddr_in,
  input logic               s_axi_awvalid_in,
  input logic               s_axi_awready_out,
  input logic               s_axi_wvalid_in,
  input logic               s_axi_wready_out,
  input logic [1:0]         s_axi_bresp_out,
  input logic               s_axi_bvalid_out,
  input logic               s_axi_bready_in,
  input logic [STCU_AW-1:0] s_axi_araddr_in,
  input logic               s_axi_arvalid_in,
  input logic               s_axi_arready_out,
  input logic [STCU_DW-1:0] s_axi_rdata_out,
  input logic [1:0]         s_axi_rresp_out,
  input logic               s_axi_rvalid_out,
  input logic               s_axi_rready_in,
  input logic [STCU_CH-1:0] capture_input_0_in,
  input logic [STCU_CH-1:0] capture_input_1_in,
  input logic [STCU_CH-1:0] toggle_output_pin_out,
  input logic [STCU_CH-1:0] capture0_irq_out,
  input logic [STCU_CH-1:0] capture1_irq_out,
  input logic [STCU_CH-1:0] match_irq_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!resetn_in);
  chk_b_retire:
    assert property (s_axi_bvalid_out && s_axi_bready_in |=> !s_axi_bvalid_out)
    else $error("write answer not retired");
  chk_r_retire:
    assert property (s_axi_rvalid_out && s_axi_rready_in |=> !s_axi_rvalid_out)
    else $error("read answer not retired");
  chk_ar_refused:
    assert property (s_axi_rvalid_out |-> !s_axi_arready_out) else $error("read taken early");
  chk_aw_refused:
    assert property (s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out)
    else $error("write taken early");
  chk_rd_unmapped:
    assert property (s_axi_arvalid_in && s_axi_arready_out && s_axi_araddr_in[5:2] > 4'h9 |=>
      s_axi_rvalid_out && s_axi_rresp_out == STCU_SLVERR && s_axi_rdata_out == STCU_ZERO32)
    else $error("unmapped read answer wrong");
  chk_wr_unmapped:
    assert property (s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in &&
      s_axi_wready_out && s_axi_awaddr_in[5:2] > 4'h9 |->
      ##[1:2] (s_axi_bvalid_out && s_axi_bresp_out == STCU_SLVERR))
    else $error("unmapped write answer wrong");
  chk_cap0_cause:
    assert property (capture0_irq_out[0] |-> $past(capture_input_0_in[0], 3) ||
      toggle_output_pin_out[3] != $past(toggle_output_pin_out[3], 3))
    else $error("capture 0 request without rising edge");
  chk_cap1_cause:
    assert property (capture1_irq_out[0] |->
      $past(capture_input_1_in[0], 3) || !$past(capture_input_0_in[0], 3))
    else $error("capture 1 request without cause");
  chk_irq_single:
    assert property (capture0_irq_out[0] |=> !capture0_irq_out[0])
    else $error("capture 0 request repeated");
  cov_cap0: cover property (capture0_irq_out[0]);
  cov_match: cover property (match_irq_out[3]);
  cov_err: cover property (s_axi_bvalid_out && s_axi_bresp_out == STCU_SLVERR);
endmodule // stcu_timer_group_props

bind stcu_timer_group stcu_timer_group_props u_props (
  .mclk_in, .resetn_in, .s_axi_awaddr_in, .s_axi_awvalid_in, .s_axi_awready_out,
  .s_axi_wvalid_in, .s_axi_wready_out, .s_axi_bresp_out, .s_axi_bvalid_out,
  .s_axi_bready_in, .s_axi_araddr_in, .s_axi_arvalid_in, .s_axi_arready_out,
  .s_axi_rdata_out, .s_axi_rresp_out, .s_axi_rvalid_out, .s_axi_rready_in,
  .capture_input_0_in, .capture_input_1_in, .toggle_output_pin_out,
  .capture0_irq_out, .capture1_irq_out, .match_irq_out
);

// ---- dv/stcu_pulse_src.sv ----
// External pulse source model for the capture and count-clock pins
`timescale 1ns/1ps
module stcu_pulse_src
  import stcu_pkg::*;
(
  input  logic               mclk_in,
  output logic [STCU_CH-1:0] pin0_out,
  output logic [STCU_CH-1:0] pin1_out
);
  initial begin
    pin0_out = '0;
    pin1_out = '0;
  end
  task automatic set0(input int ch, input logic v);
    pin0_out[ch] <= v;
  endtask
  task automatic set1(input int ch, input logic v);
    pin1_out[ch] <= v;
  endtask
  // Event train on input 0, w clocks high then w low
  task automatic burst0(input int ch, input int n, input int w);
    repeat (n) begin
      pin0_out[ch] <= 1'b1;
      repeat (w) @(posedge mclk_in);
      pin0_out[ch] <= 1'b0;
      repeat (w) @(posedge mclk_in);
    end
  endtask
endmodule // stcu_pulse_src

// ---- dv/tb_top.sv ----
// Register-level testbench of the timer group
`timescale 1ns/1ps
module tb_top
  import stcu_pkg::*;
;
  logic               mclk_in = 1'b0;
  logic               resetn_in = 1'b0;
  logic [STCU_AW-1:0] awaddr = '0, araddr = '0;
  logic [STCU_DW-1:0] wdata = '0, rdata, d, e;
  logic               awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
  logic               awready, wready, bvalid, arready, rvalid;
  logic [1:0]         bresp, rresp, r;
  logic [STCU_CH-1:0] pin0, pin1, tgl, irq0, irq1, irqm;
  int                 bad_count = 0, num_checks = 0, n0 = 0, n1 = 0, nm = 0, k = 0;

  always #25 mclk_in = ~mclk_in;
  always @(posedge mclk_in) begin
    n0 <= n0 + int'(irq0[0]);
    n1 <= n1 + int'(irq1[0]);
    nm <= nm + int'(irqm[3]);
  end

  stcu_pulse_src src (.mclk_in(mclk_in), .pin0_out(pin0), .pin1_out(pin1));
  stcu_timer_group dut (
    .mclk_in(mclk_in), .resetn_in(resetn_in),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
    .s_axi_bready_in(1'b1), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rvalid), .s_axi_rready_in(1'b1),
    .capture_input_0_in(pin0), .capture_input_1_in(pin1),
    .toggle_output_pin_out(tgl), .capture0_irq_out(irq0), .capture1_irq_out(irq1),
    .match_irq_out(irqm)
  );

  task automatic end_of_test();
    if (bad_count == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    num_checks++;
    if (g !== x) begin
      bad_count++;
      $display("[ERR] %0t got %h expected %h", $time, g, x);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_in);
  endtask
  // Address and data offered together, each released once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] s);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge mclk_in);
      ad = ad | awready;
      wd = wd | wready;
      awvalid <= !ad;
      wvalid <= !wd;
    end
    do @(posedge mclk_in); while (!bvalid);
    s = bresp;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] s);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge mclk_in); while (!arready);
    arvalid <= 1'b0;
    do @(posedge mclk_in); while (!rvalid);
    v = rdata;
    s = rresp;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] v;
    logic [1:0]  s;
    rd(a, v, s);
    chk(v, x);
    chk(32'(s), 32'(STCU_OKAY));
  endtask

  initial begin
    tick(20000);
    bad_count++;
    end_of_test();
  end

  initial begin
    tick(20);
    resetn_in <= 1'b1;
    for (int i = 0; i < 10; i++) rc(8'(i * 4), STCU_ZERO32);
    rd(8'h28, d, r);
    chk(d, STCU_ZERO32);
    chk(32'(r), 32'(STCU_SLVERR));
    wr(8'h3c, 32'h1, r);
    chk(32'(r), 32'(STCU_SLVERR));
    wr(8'h20, 32'h1234, r);
    chk(32'(r), 32'(STCU_OKAY));
    rc(8'h20, STCU_ZERO32);
    wr(8'h10, 32'hffff_abcd, r);
    rc(8'h10, 32'h0000_abcd);
    // Group start: ch1 and ch2 follow ch0, ch3 stays alone
    wr(8'h04, 32'h0, r);
    wr(8'h44, 32'h1, r);
    wr(8'h84, 32'h1, r);
    wr(8'h08, 32'h2, r);
    wr(8'h48, 32'h2, r);
    wr(8'h00, 32'h5, r);
    tick(20);
    rc(8'h64, 32'h2);
    rc(8'ha4, 32'h2);
    rc(8'he4, 32'h0);
    rc(8'he0, 32'h0);
    src.set0(0, 1'b1);
    src.set0(1, 1'b1);
    tick(80);
    src.set1(0, 1'b1);
    tick(20);
    rd(8'h18, d, r);
    rd(8'h58, e, r);
    chk(e, d);
    rd(8'h1c, e, r);
    chk(32'(16'(e[15:0] - d[15:0])), 32'd10);
    chk(n0, 1);
    chk(n1, 1);
    src.set0(0, 1'b0);
    src.set0(1, 1'b0);
    src.set1(0, 1'b0);
    // Falling edges must clear the synchroniser before the capture modes change
    tick(5);
    // Both edges of input 0 on ch0; ch1 follows ch0's toggle output
    wr(8'h08, 32'h4, r);
    wr(8'h0c, 32'h4, r);
    wr(8'h48, 32'h6, r);
    src.set0(0, 1'b1);
    tick(10);
    chk(32'(tgl[0]), 32'd1);
    tick(70);
    src.set0(0, 1'b0);
    tick(160);
    src.set0(0, 1'b1);
    tick(20);
    rd(8'h18, d, r);
    rd(8'h1c, e, r);
    chk(32'(16'(d[15:0] - e[15:0])), 32'd20);
    chk(n1, 2);
    rd(8'h58, d, r);
    rd(8'h5c, e, r);
    chk(32'(16'(e[15:0] - d[15:0])), 32'd30);
    chk(32'(tgl[0]), 32'd0);
    // One-shot on ch3: toggle at count 3 and count 6
    wr(8'hd0, 32'h3, r);
    wr(8'hd4, 32'h6, r);
    wr(8'hcc, 32'h3, r);
    wr(8'hc0, 32'h5, r);
    while (!tgl[3]) @(posedge mclk_in);
    while (tgl[3]) begin
      @(posedge mclk_in);
      k++;
    end
    chk(k, 24);
    tick(1);
    chk(nm, 1);
    wr(8'hcc, 32'h0, r);
    // Event counting from input 0 of ch3
    wr(8'hc0, 32'h0, r);
    wr(8'hc8, 32'h1, r);
    wr(8'hc0, 32'h5, r);
    src.burst0(3, 5, 4);
    tick(10);
    rc(8'he0, 32'h5);
    end_of_test();
  end
endmodule // tb_top
